/* verilog/reset_sequencer.sv */
// Purpose: Reset sequencer merging pin, supply-drop and watchdog causes,
//          with clock source and multiplier selection.
// Assumes: clock_in is the 20 MHz CPU clock; reset_in is synchronous high.
// Notes:   The pin input is caught by an asynchronous latch so halt mode
//          (no clock) still enters reset.
//
// Notes on behaviour
// - Three causes all pull reset pin low.
// - Active, delay, then vector fetch phases.
// - Delay is 256 or 4096 cycles.
// - Vector fetch lasts exactly two cycles.
// - Reset vector sits at FFFE-FFFF.
// - Reset pin is input and open-drain output.
// - External detection works without the clock.
// - Power-on and drop resets hold pin low.
// - Watchdog drives pin low minimum time.
// - Two flags record watchdog and supply-drop resets; pin resets set neither.
// - Multiplier off gives oscillator clock halved.
// - Multiplier on doubles 2-4 MHz input.
// - Clock source chosen by configuration.
// - Resonators keep running during reset.
module reset_sequencer (
   input  wire logic                 clock_in,
   input  wire logic                 reset_in,
   input  wire logic                 rst_pin_in,
   output logic                      rst_pin_out,
   output logic                      rst_pin_oe_out,
   input  wire logic                 supply_low_in,
   input  wire logic                 power_on_in,
   input  wire logic                 wdg_underflow_in,
   input  wire rst_seq_pkg::reg_req_t req_in,
   output logic [7:0]                rdata_out,
   output logic                      irq_out,
   output logic                      cpu_reset_out,
   output logic                      vector_fetch_out,
   output logic [15:0]               fetch_addr_out,
   output logic                      osc_run_out,
   output logic [2:0]                clock_source_selector_out,
   output logic                      mult_en_out,
   output logic                      core_div2_out
);

   // ==========================================================================
   // Asynchronous pin catch
   // ==========================================================================
   // Latch set by a low pin level without any clock, cleared once counted.
   logic ext_seen_q;
   logic ext_ack;
   // Our own drive, plus one cycle after release, must not look like a press.
   logic own_q;
   wire  pin_free_n = rst_pin_in | rst_pin_oe_out | own_q;
   // The pin low forces the catch asynchronously, so halt still resets.
   always_ff @(posedge clock_in or negedge pin_free_n) begin
      if (!pin_free_n) begin
         ext_seen_q <= 1'b1;
      end else if (ext_ack) begin
         ext_seen_q <= 1'b0;
      end
   end

   // Three flop synchroniser on the pin level with our own drive masked; second and third agree.
   logic [2:0] pin_sync_q;
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         pin_sync_q <= 3'h7;
         own_q      <= 1'b1;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], pin_free_n};
         own_q      <= rst_pin_oe_out;
      end
   end
   // Pin held low as seen by our own logic, ignoring our own drive.
   wire pin_low_sync = (pin_sync_q[2] == 1'b0) && (pin_sync_q[1] == 1'b0);

   // Synchronised copy of the asynchronous catch; flops two and three must agree.
   logic [2:0] ext_sync_q;
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         ext_sync_q <= 3'h0;
      end else begin
         ext_sync_q <= {ext_sync_q[1:0], ext_seen_q};
      end
   end
   // A caught pin pulse; short glitches are accepted too, which is safe.
   wire ext_cause = ext_sync_q[2] & ext_sync_q[1];

   // ==========================================================================
   // Cause inputs and watchdog stretch
   // ==========================================================================
   // Supply detector and watchdog come from on-chip logic on this clock.
   localparam logic [4:0] WDG_CYC = 5'(rst_seq_pkg::MIN_WDG_DRIVE_CYC);
   logic [4:0] wdg_cnt_q;
   logic [4:0] wdg_cnt_d;
   // Hold the watchdog cause for the least drive time from the underflow.
   assign wdg_cnt_d = wdg_underflow_in        ? WDG_CYC :
                      (wdg_cnt_q != 5'h00)    ? wdg_cnt_q - 5'h01 : 5'h00;
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         wdg_cnt_q <= 5'h00;
      end else begin
         wdg_cnt_q <= wdg_cnt_d;
      end
   end
   wire wdg_cause = wdg_underflow_in | (wdg_cnt_q != 5'h00);
   // Supply detector holds reset while it says the supply is low.
   wire sup_cause = supply_low_in;
   // Any of the three causes. The pin itself stays counted while held low.
   wire any_cause = ext_cause | sup_cause | wdg_cause | pin_low_sync;
   // The catch is released once the clocked side has counted it.
   assign ext_ack = ext_sync_q[2] & rst_pin_in;

   // ==========================================================================
   // Configuration register
   // ==========================================================================
   logic [7:0] config_q;
   // Register port decode.
   wire wr_cause  = req_in.wr && (req_in.addr == rst_seq_pkg::ADDR_CAUSE);
   wire wr_config = req_in.wr && (req_in.addr == rst_seq_pkg::ADDR_CONFIG);
   wire wr_status = req_in.wr && (req_in.addr == rst_seq_pkg::ADDR_STATUS);
   wire wr_mask   = req_in.wr && (req_in.addr == rst_seq_pkg::ADDR_MASK);
   wire [2:0] src_raw  = req_in.wdata[rst_seq_pkg::POS_SRC +: 3];
   // The multiplier bit is refused together with the RC source.
   wire mult_req = req_in.wdata[rst_seq_pkg::BIT_MULT_EN] &&
                   (src_raw != rst_seq_pkg::SRC_RC);
   // Unused source codes fall back to the external clock input.
   wire [2:0] src_ok = (src_raw > rst_seq_pkg::SRC_RC) ? rst_seq_pkg::SRC_EXT : src_raw;
   wire [7:0] config_wr = {1'b0, src_ok, 2'b00, mult_req,
                           req_in.wdata[rst_seq_pkg::BIT_LONG_DELAY]};
   // Configuration survives sequencer resets; only reset_in restores it.
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         config_q <= rst_seq_pkg::CONFIG_RESET;
      end else if (wr_config) begin
         config_q <= config_wr;
      end
   end
   wire long_delay = config_q[rst_seq_pkg::BIT_LONG_DELAY];

   // ==========================================================================
   // Phase sequencer
   // ==========================================================================
   rst_seq_pkg::phase_t phase_q;
   rst_seq_pkg::phase_t phase_d;
   logic [12:0] delay_cnt_q;
   logic [1:0]  fetch_cnt_q;
   // Software picks the delay to suit its oscillator start-up.
   wire [12:0] delay_len = long_delay ? rst_seq_pkg::DELAY_LONG_CYC
                                      : rst_seq_pkg::DELAY_SHORT_CYC;
   wire delay_done = (delay_cnt_q == delay_len - 13'h0001);
   wire fetch_done = (fetch_cnt_q == rst_seq_pkg::FETCH_CYC - 2'h1);

   // Next phase; a cause during delay or fetch sends it back to active.
   always_comb begin
      phase_d = phase_q;
      case (phase_q)
         rst_seq_pkg::PH_ACTIVE: begin
            if (!any_cause) begin
               phase_d = rst_seq_pkg::PH_DELAY;
            end
         end
         rst_seq_pkg::PH_DELAY: begin
            if (any_cause) begin
               phase_d = rst_seq_pkg::PH_ACTIVE;
            end else if (delay_done) begin
               phase_d = rst_seq_pkg::PH_FETCH;
            end
         end
         rst_seq_pkg::PH_FETCH: begin
            if (any_cause) begin
               phase_d = rst_seq_pkg::PH_ACTIVE;
            end else if (fetch_done) begin
               phase_d = rst_seq_pkg::PH_RUN;
            end
         end
         rst_seq_pkg::PH_RUN: begin
            if (any_cause) begin
               phase_d = rst_seq_pkg::PH_ACTIVE;
            end
         end
         default: begin
            phase_d = rst_seq_pkg::PH_ACTIVE;
         end
      endcase
   end

   // Phase register and the two counters, zeroed outside their phase.
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         phase_q     <= rst_seq_pkg::PH_ACTIVE;
         delay_cnt_q <= 13'h0000;
         fetch_cnt_q <= 2'h0;
      end else begin
         phase_q     <= phase_d;
         delay_cnt_q <= (phase_q == rst_seq_pkg::PH_DELAY && !any_cause)
                        ? delay_cnt_q + 13'h0001 : 13'h0000;
         fetch_cnt_q <= (phase_q == rst_seq_pkg::PH_FETCH && !any_cause)
                        ? fetch_cnt_q + 2'h1 : 2'h0;
      end
   end

   // ==========================================================================
   // Cause flags
   // ==========================================================================
   logic wdg_flag_q;
   logic uv_flag_q;
   // Hardware sets win over software clears; supply drop clears the
   // watchdog flag, and a pin reset leaves both untouched.
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         wdg_flag_q <= 1'b0;
         uv_flag_q  <= 1'b0;
      end else begin
         if (sup_cause) begin
            uv_flag_q  <= 1'b1;
            wdg_flag_q <= 1'b0;
         end else begin
            if (wdg_underflow_in) begin
               wdg_flag_q <= 1'b1;
            end else if (wr_cause && !req_in.wdata[rst_seq_pkg::BIT_WDG_FLAG]) begin
               wdg_flag_q <= 1'b0;
            end
            if (wr_cause && !req_in.wdata[rst_seq_pkg::BIT_UV_FLAG]) begin
               uv_flag_q <= 1'b0;
            end
         end
      end
   end

   // ==========================================================================
   // Interrupt status and mask
   // ==========================================================================
   logic [3:0] status_q;
   logic [3:0] mask_q;
   logic       run_q;
   wire [3:0] events;
   assign events[rst_seq_pkg::EV_EXT]  = ext_cause;
   assign events[rst_seq_pkg::EV_SUP]  = sup_cause;
   assign events[rst_seq_pkg::EV_WDG]  = wdg_underflow_in;
   assign events[rst_seq_pkg::EV_DONE] = (phase_q == rst_seq_pkg::PH_RUN) & ~run_q;
   // Sticky bits: write one clears, a new event in the same cycle wins.
   genvar gi;
   generate
      for (gi = 0; gi < rst_seq_pkg::EV_COUNT; gi++) begin : g_status
         always_ff @(posedge clock_in) begin
            if (reset_in) begin
               status_q[gi] <= 1'b0;
            end else if (events[gi]) begin
               status_q[gi] <= 1'b1;
            end else if (wr_status && req_in.wdata[gi]) begin
               status_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Mask register and run-edge helper.
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         mask_q <= 4'h0;
         run_q  <= 1'b0;
      end else begin
         run_q <= (phase_q == rst_seq_pkg::PH_RUN);
         if (wr_mask) begin
            mask_q <= req_in.wdata[3:0];
         end
      end
   end

   // ==========================================================================
   // Read data
   // ==========================================================================
   wire [7:0] cause_rd = {3'h0, uv_flag_q, 3'h0, wdg_flag_q};
   wire [7:0] rd_mux = (req_in.addr == rst_seq_pkg::ADDR_CAUSE)  ? cause_rd :
                       (req_in.addr == rst_seq_pkg::ADDR_CONFIG) ? config_q :
                       (req_in.addr == rst_seq_pkg::ADDR_STATUS) ? {4'h0, status_q} :
                       (req_in.addr == rst_seq_pkg::ADDR_MASK)   ? {4'h0, mask_q} :
                       8'h00;

   // ==========================================================================
   // Registered outputs
   // ==========================================================================
   // Everything leaves from a flop; read data stands one cycle after the strobe.
   wire in_reset = (phase_d == rst_seq_pkg::PH_ACTIVE) ||
                   (phase_d == rst_seq_pkg::PH_DELAY);
   wire [2:0] src_sel = config_q[rst_seq_pkg::POS_SRC +: 3];
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         rdata_out                 <= 8'h00;
         irq_out                   <= 1'b0;
         rst_pin_out               <= 1'b0;
         rst_pin_oe_out            <= 1'b1;
         cpu_reset_out             <= 1'b1;
         vector_fetch_out          <= 1'b0;
         fetch_addr_out            <= rst_seq_pkg::RESET_VECTOR_ADDR;
         osc_run_out               <= 1'b1;
         clock_source_selector_out <= rst_seq_pkg::SRC_EXT;
         mult_en_out               <= 1'b0;
         core_div2_out             <= 1'b1;
      end else begin
         rdata_out      <= req_in.rd ? rd_mux : 8'h00;
         irq_out        <= |(status_q & mask_q);
         // Open drain: only ever drive low, enable in delay, and in active only for supply, watchdog or power-on.
         rst_pin_out    <= 1'b0;
         rst_pin_oe_out <= in_reset && (phase_d != rst_seq_pkg::PH_ACTIVE
                           || sup_cause || wdg_cause || power_on_in);
         cpu_reset_out  <= (phase_d != rst_seq_pkg::PH_RUN);
         vector_fetch_out <= (phase_d == rst_seq_pkg::PH_FETCH);
         // Low then high byte of the vector word.
         fetch_addr_out <= rst_seq_pkg::RESET_VECTOR_ADDR |
                           {15'h0000, (phase_d == rst_seq_pkg::PH_FETCH) &&
                            (phase_q == rst_seq_pkg::PH_FETCH)};
         // Resonators, like all sources, keep running through reset.
         osc_run_out    <= 1'b1;
         clock_source_selector_out <= src_sel;
         mult_en_out    <= config_q[rst_seq_pkg::BIT_MULT_EN];
         core_div2_out  <= ~config_q[rst_seq_pkg::BIT_MULT_EN];
      end
   end

endmodule

/* shared/rst_seq_pkg.sv */
// Purpose: Shared constants and types for the reset sequencer and clock select.
// Assumes: One 20 MHz system clock; register port with one-cycle read latency.
// Notes:   Offsets, field positions, timing counts and the config reset value live here.
package rst_seq_pkg;

   // ==========================================================================
   // Clock and timing
   // ==========================================================================
   // System clock period in nanoseconds.
   localparam int unsigned CLK_PERIOD_NS     = 50;
   // Short and long stabilisation delays, in CPU cycles.
   localparam logic [12:0] DELAY_SHORT_CYC   = 13'h0100;
   localparam logic [12:0] DELAY_LONG_CYC    = 13'h1000;
   // Vector fetch phase length, in CPU cycles.
   localparam logic [1:0]  FETCH_CYC         = 2'h2;
   // Least watchdog drive time on the reset pin, in nanoseconds.
   localparam int unsigned MIN_WDG_DRIVE_NS  = 500;
   // Least watchdog drive in system cycles, rounded up.
   localparam int unsigned MIN_WDG_DRIVE_CYC =
      (MIN_WDG_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Least external pulse width, in nanoseconds, and in cycles rounded up.
   localparam int unsigned MIN_EXT_PULSE_NS  = 100;
   localparam int unsigned MIN_EXT_PULSE_CYC =
      (MIN_EXT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Reset vector address.
   localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;

   // ==========================================================================
   // Register map
   // ==========================================================================
   localparam logic [3:0] ADDR_CAUSE  = 4'h0;
   localparam logic [3:0] ADDR_CONFIG = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_MASK   = 4'hC;
   // Cause register fields.
   localparam int unsigned BIT_WDG_FLAG = 0;
   localparam int unsigned BIT_UV_FLAG  = 4;
   // Config register fields.
   localparam int unsigned BIT_LONG_DELAY = 0;
   localparam int unsigned BIT_MULT_EN    = 1;
   localparam int unsigned POS_SRC        = 4;
   // Config reset value: long delay, no multiplier, external clock.
   localparam logic [7:0] CONFIG_RESET = 8'h01;
   // Event status bits.
   localparam int unsigned EV_EXT   = 0;
   localparam int unsigned EV_SUP   = 1;
   localparam int unsigned EV_WDG   = 2;
   localparam int unsigned EV_DONE  = 3;
   localparam int unsigned EV_COUNT = 4;

   // ==========================================================================
   // Types
   // ==========================================================================
   // Clock source choices.
   typedef enum logic [2:0] {
      SRC_EXT   = 3'h0,
      SRC_XTAL0 = 3'h1,
      SRC_XTAL1 = 3'h2,
      SRC_XTAL2 = 3'h3,
      SRC_XTAL3 = 3'h4,
      SRC_XTAL4 = 3'h5,
      SRC_RC    = 3'h6
   } clk_src_t;

   // Sequencer phases, one-hot.
   typedef enum logic [3:0] {
      PH_ACTIVE = 4'h1,
      PH_DELAY  = 4'h2,
      PH_FETCH  = 4'h4,
      PH_RUN    = 4'h8
   } phase_t;

   // Register port request.
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

endpackage

/* verif/reset_sequencer_checker.sv */
// Purpose: Port-level checks of the reset sequencer.
// Assumes: One clock; reset_in synchronous high.
// Notes:   Delay window allows sync and stretch slack.
module reset_sequencer_checker (
   input wire logic                  clock_in,
   input wire logic                  reset_in,
   input wire logic                  rst_pin_in,
   input wire logic                  rst_pin_out,
   input wire logic                  rst_pin_oe_out,
   input wire logic                  supply_low_in,
   input wire logic                  wdg_underflow_in,
   input wire rst_seq_pkg::reg_req_t req_in,
   input wire logic                  cpu_reset_out,
   input wire logic                  vector_fetch_out,
   input wire logic [15:0]           fetch_addr_out,
   input wire logic                  osc_run_out,
   input wire logic                  mult_en_out,
   input wire logic                  core_div2_out
);
   // ==========================================================================
   // Helper logic
   // ==========================================================================
   logic [13:0] quiet_q;   // Cycles since the last reset cause.
   logic        long_q;    // Long delay chosen by software.
   logic        cause_now; // A cause is present, own pin drive excluded.
   logic        dly_ok;    // Quiet span fits the chosen delay.
   assign cause_now = supply_low_in | wdg_underflow_in | (!rst_pin_in & !rst_pin_oe_out)
                      | (cpu_reset_out & !rst_pin_oe_out & !vector_fetch_out);
   assign dly_ok = long_q ? (quiet_q >= 14'h1000 && quiet_q <= 14'h1010)
                          : (quiet_q >= 14'h0100 && quiet_q <= 14'h0110);
   // The counter saturates so a long run never wraps into a false pass.
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         quiet_q <= 14'h0000;
         long_q  <= 1'b1;
      end else begin
         quiet_q <= cause_now ? 14'h0000 : quiet_q + {13'h0000, quiet_q != 14'h3FFF};
         if (req_in.wr && req_in.addr == rst_seq_pkg::ADDR_CONFIG) begin
            long_q <= req_in.wdata[rst_seq_pkg::BIT_LONG_DELAY];
         end
      end
   end
   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (reset_in);
   sequence s_fetch_start;
      $rose(vector_fetch_out);
   endsequence
   a_pin_never_high: assert property (rst_pin_out == 1'b0)
      else $error("reset pin driven high");
   a_osc_kept_running: assert property (osc_run_out)
      else $error("oscillator stopped");
   a_div_follows_mult: assert property (core_div2_out == !mult_en_out)
      else $error("divide select wrong");
   a_fetch_two_cycles: assert property (s_fetch_start |-> vector_fetch_out ##1
      vector_fetch_out ##1 !vector_fetch_out) else $error("fetch length wrong");
   a_vector_addr_order: assert property (s_fetch_start |-> fetch_addr_out == 16'hFFFE
      ##1 fetch_addr_out == 16'hFFFF) else $error("vector address wrong");
   a_delay_length: assert property (s_fetch_start |-> dly_ok)
      else $error("delay length wrong");
   a_run_after_fetch: assert property ($fell(cpu_reset_out) |-> $past(vector_fetch_out))
      else $error("run without fetch");
   a_wdg_pin_drive: assert property (wdg_underflow_in |-> ##[1:3] rst_pin_oe_out
      ##1 rst_pin_oe_out [*8]) else $error("watchdog drive short");
   a_supply_pin_drive: assert property (supply_low_in ##1 supply_low_in |->
      ##[0:2] rst_pin_oe_out) else $error("supply drop not driven");
   a_ext_enters_reset: assert property ($fell(rst_pin_in) && !rst_pin_oe_out |->
      ##[1:6] cpu_reset_out) else $error("pin reset missed");
endmodule

bind reset_sequencer reset_sequencer_checker reset_sequencer_checker_i (
   .clock_in(clock_in), .reset_in(reset_in), .rst_pin_in(rst_pin_in),
   .rst_pin_out(rst_pin_out), .rst_pin_oe_out(rst_pin_oe_out),
   .supply_low_in(supply_low_in), .wdg_underflow_in(wdg_underflow_in), .req_in(req_in),
   .cpu_reset_out(cpu_reset_out), .vector_fetch_out(vector_fetch_out),
   .fetch_addr_out(fetch_addr_out), .osc_run_out(osc_run_out),
   .mult_en_out(mult_en_out), .core_div2_out(core_div2_out));

/* verif/reset_pin_partner.sv */
// Purpose: Board side of the reset pin: button and pull-up.
// Assumes: Pull-up gives high when nobody drives low.
// Notes:   Asynchronous, works with the clock stopped.
module reset_pin_partner (
   input  wire logic press_in,
   input  wire logic drive_en_in,
   input  wire logic drive_val_in,
   output logic      pin_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic hold_q = 1'b0; // Board pulls the pin low.
   // A press is never shorter than the least recognised width.
   always @(posedge press_in) begin
      hold_q = 1'b1;
      #(rst_seq_pkg::MIN_EXT_PULSE_NS);
      wait (press_in == 1'b0);
      hold_q = 1'b0;
   end
   // Wired level: any low driver wins, else the pull-up.
   assign pin_out = (hold_q || (drive_en_in && drive_val_in == 1'b0)) ? 1'b0 : 1'b1;
endmodule

/* verif/reset_sequencer_tb_top.sv */
// Purpose: Self-checking bench for the reset sequencer.
// Assumes: 20 MHz clock; config survives sequencer resets.
// Notes:   Model values are plain integers.
module reset_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock_in = 0, reset_in = 1, supply_low_in = 0, power_on_in = 0;
   logic wdg_underflow_in = 0, clk_run = 1, press = 0, rst_pin_in;
   logic rst_pin_out, rst_pin_oe_out, irq_out, cpu_reset_out, vector_fetch_out;
   logic osc_run_out, mult_en_out, core_div2_out;
   logic [7:0] rdata_out;
   logic [15:0] fetch_addr_out;
   logic [2:0] clock_source_selector_out;
   rst_seq_pkg::reg_req_t req_in = '0;
   int errors = 0, compares = 0, n, es, em, mlt;
   // ==========================================================================
   // Clock, even duty; stoppable to mimic halt mode
   // ==========================================================================
   always #25 clock_in = clk_run ? ~clock_in : clock_in;
   reset_sequencer reset_sequencer_i (.clock_in(clock_in), .reset_in(reset_in),
      .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe_out(rst_pin_oe_out),
      .supply_low_in(supply_low_in), .power_on_in(power_on_in),
      .wdg_underflow_in(wdg_underflow_in), .req_in(req_in), .rdata_out(rdata_out),
      .irq_out(irq_out), .cpu_reset_out(cpu_reset_out), .vector_fetch_out(vector_fetch_out),
      .fetch_addr_out(fetch_addr_out), .osc_run_out(osc_run_out),
      .clock_source_selector_out(clock_source_selector_out), .mult_en_out(mult_en_out),
      .core_div2_out(core_div2_out));
   reset_pin_partner reset_pin_partner_i (.press_in(press), .drive_en_in(rst_pin_oe_out),
      .drive_val_in(rst_pin_out), .pin_out(rst_pin_in));
   // ==========================================================================
   // Tasks
   // ==========================================================================
   task automatic check(input logic [15:0] got, input int exp, input string what);
      compares++;
      if (got !== exp[15:0]) begin
         errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp[15:0]);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_in) req_in <= '{a, d, 1'b1, 1'b0};
      @(posedge clock_in) req_in <= '0;
   endtask
   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [3:0] a, input logic [7:0] m, input int exp, input string w);
      @(posedge clock_in) req_in <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock_in) req_in <= '0;
      #1 check({8'h00, rdata_out & m}, exp, w);
   endtask
   // Bounded wait for the run phase; n counts cycles.
   task automatic wait_done(input int lo, input int hi);
      n = 0;
      while (cpu_reset_out !== 1'b0 && n < 6000) begin
         @(posedge clock_in);
         n++;
      end
      check(16'(n >= lo && n <= hi), 1, "delay span");
   endtask
   task automatic pulse_wdg;
      @(posedge clock_in) wdg_underflow_in <= 1'b1;
      @(posedge clock_in) wdg_underflow_in <= 1'b0;
   endtask
   task automatic stop_test;
      if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog against a hang.
   initial begin
      #2000000;
      errors++;
      $display("[ERR] %0t run hung", $time);
      stop_test;
   end
   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      void'($urandom(9));
      repeat (8) @(posedge clock_in);
      reset_in <= 1'b0;
      wait_done(4096, 4120);
      rd(rst_seq_pkg::ADDR_CONFIG, 8'hFF, 'h01, "config reset");
      rd(4'h2, 8'hFF, 0, "unmapped");
      for (int s = 0; s < 8; s++) begin
         mlt = (s == 6) ? 1 : $urandom % 2;
         wr(rst_seq_pkg::ADDR_CONFIG, 8'((s << 4) | (mlt << 1) | 1));
         es = (s == 7) ? 0 : s;
         em = (es == 6) ? 0 : mlt;
         rd(rst_seq_pkg::ADDR_CONFIG, 8'h73, (es << 4) | (em << 1) | 1, "config");
         check({13'h0, clock_source_selector_out}, es, "source");
         check({15'h0, mult_en_out}, em, "mult");
      end
      wr(rst_seq_pkg::ADDR_CONFIG, 8'h00);
      wr(rst_seq_pkg::ADDR_STATUS, 8'hFF);
      pulse_wdg;
      repeat (3) @(posedge clock_in);
      for (int i = 0; i < rst_seq_pkg::MIN_WDG_DRIVE_CYC; i++) begin
         #1 check({15'h0, rst_pin_in}, 0, "wdg pin");
         @(posedge clock_in);
      end
      wait_done(256, 290);
      rd(rst_seq_pkg::ADDR_CAUSE, 8'h11, 'h01, "wdg cause");
      rd(rst_seq_pkg::ADDR_STATUS, 8'h0E, 'h0C, "wdg status");
      wr(rst_seq_pkg::ADDR_MASK, 8'h04);
      repeat (2) @(posedge clock_in);
      check({15'h0, irq_out}, 1, "irq on");
      wr(rst_seq_pkg::ADDR_MASK, 8'h00);
      repeat (2) @(posedge clock_in);
      check({15'h0, irq_out}, 0, "irq masked");
      wr(rst_seq_pkg::ADDR_MASK, 8'h04);
      wr(rst_seq_pkg::ADDR_STATUS, 8'h04);
      repeat (2) @(posedge clock_in);
      check({15'h0, irq_out}, 0, "irq cleared");
      wr(rst_seq_pkg::ADDR_MASK, 8'h00);
      // Supply drop, then power-on flavour.
      for (int p = 0; p < 2; p++) begin
         wr(rst_seq_pkg::ADDR_STATUS, 8'hFF);
         @(posedge clock_in) supply_low_in <= 1'b1;
         power_on_in <= 1'(p);
         repeat (20 + $urandom % 30) @(posedge clock_in);
         check({14'h0, rst_pin_in, cpu_reset_out}, 1, "supply hold");
         supply_low_in <= 1'b0;
         power_on_in <= 1'b0;
         wait_done(256, 290);
         rd(rst_seq_pkg::ADDR_CAUSE, 8'h11, 'h10, "uv cause");
         rd(rst_seq_pkg::ADDR_STATUS, 8'h0E, 'h0A, "uv status");
      end
      // Pin reset, clock running and then stopped.
      wr(rst_seq_pkg::ADDR_CAUSE, 8'h00);
      for (int h = 0; h < 2; h++) begin
         wr(rst_seq_pkg::ADDR_STATUS, 8'hFF);
         @(negedge clock_in) clk_run = 1'(!h);
         press = 1'b1;
         #300 press = 1'b0;
         #200 clk_run = 1'b1;
         repeat (6) @(posedge clock_in);
         check({15'h0, cpu_reset_out}, 1, "pin reset");
         wait_done(250, 290);
         rd(rst_seq_pkg::ADDR_CAUSE, 8'h11, 'h00, "pin cause");
         rd(rst_seq_pkg::ADDR_STATUS, 8'h0F, 'h09, "pin status");
      end
      // A new cause in mid-delay restarts the full count.
      wr(rst_seq_pkg::ADDR_CONFIG, 8'h01);
      pulse_wdg;
      repeat (2000) @(posedge clock_in);
      supply_low_in <= 1'b1;
      repeat (5) @(posedge clock_in);
      supply_low_in <= 1'b0;
      wait_done(4096, 4130);
      stop_test;
   end
endmodule
